/* bench/ddmc_ctl_model.sv */
`timescale 1ns/100ps
`default_nettype none
module ddmc_ctl_model
  import ddmc_pkg::*;
#(
  parameter int SRE_HOLD = 5,
  parameter int SRX_STABLE = 5,
  parameter int XS_DELAY = 8
)
(
  // Link toward the device
  output logic ck_link,
  output ddmc_cmd_s link_cmd,
  output logic link_odt
);
  logic run = 1'b1;
  int cyc = 0;

  // The clock parks low when stopped, so no short pulse reaches the device.
  initial
  begin
    ck_link = 1'b0;
    link_cmd = {1'b1, 4'hF, 17'h0_0000};
    link_odt = 1'b0;
    #1.3;
    forever
      #15 if (run || ck_link) ck_link = ~ck_link;
  end

  always @(posedge ck_link)
    cyc <= cyc + 1;

  task automatic wait_ck(input int n);
    repeat (n) @(posedge ck_link);
  endtask : wait_ck

  // Deselect follows at once; the unused fields show the inverse, not a stale copy.
  task automatic issue(input logic cke, input logic [2:0] op, input logic [2:0] ba,
                       input logic [13:0] a, output int k);
    @(posedge ck_link);
    k = cyc;
    link_cmd <= {cke, 1'b0, op, ba, a};
    @(posedge ck_link);
    link_cmd <= {cke, 4'hF, ~ba, ~a};
  endtask : issue

  task automatic mrs(input logic [2:0] ba, input logic [13:0] a, input int w);
    int k;
    issue(1'b1, 3'b000, ba, a, k);
    wait_ck(w);
  endtask : mrs

  task automatic sref_in();
    int k;
    issue(1'b0, 3'b001, 3'h0, 14'h0000, k);
    wait_ck(SRE_HOLD);
    run = 1'b0;
  endtask : sref_in

  task automatic sref_out();
    run = 1'b1;
    wait_ck(SRX_STABLE);
    link_cmd.cke <= 1'b1;
    wait_ck(XS_DELAY);
  endtask : sref_out
endmodule : ddmc_ctl_model
`default_nettype wire

/* bench/ddmc_mode_ctrl_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module ddmc_mode_ctrl_chk
  import ddmc_pkg::*;
(
  // Clocks and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ck_link,
  // Link side
  input wire ddmc_cmd_s link_cmd,
  input wire logic link_odt,
  input wire logic rd_strobe_start,
  input wire logic wr_data_start,
  input wire logic odt_on,
  input wire logic link_dll_off
);
  logic cke_q_r;
  logic sref_r;
  logic [1:0] al_r;
  logic [2:0] op;
  logic go;
  assign op = {link_cmd.ras_n, link_cmd.cas_n, link_cmd.we_n};
  assign go = !link_cmd.cs_n && cke_q_r && !sref_r;

  always_ff @(posedge ck_link or negedge rst_b)
    if (!rst_b)
      cke_q_r <= 1'b0;
    else
      cke_q_r <= link_cmd.cke;

  // Tracks sleep so the quiet check knows when no answer may start.
  always_ff @(posedge ck_link or negedge rst_b)
    if (!rst_b)
      sref_r <= 1'b0;
    else if (sref_r)
      sref_r <= !link_cmd.cke;
    else if (go && !link_cmd.cke && op == 3'b001)
      sref_r <= 1'b1;

  always_ff @(posedge ck_link or negedge rst_b)
    if (!rst_b)
      al_r <= 2'b00;
    else if (go && op == 3'b000 && link_cmd.ba == DDMC_MR1_SEL)
      al_r <= link_cmd.addr[DDMC_MR1_AL_HI:DDMC_MR1_AL_LO];

  chk_rd_dll_off: assert property (@(posedge ck_link) disable iff (!rst_b)
    go && op == 3'b101 && link_dll_off && al_r == 2'b00
    |-> ##1 !rd_strobe_start [*5] ##1 rd_strobe_start)
    else $error("read strobe start misplaced with DLL off");
  chk_rd_dll_on: assert property (@(posedge ck_link) disable iff (!rst_b)
    go && op == 3'b101 && !link_dll_off |-> ##1 !rd_strobe_start [*4])
    else $error("read strobe start too early with DLL on");
  chk_wr_dll_off: assert property (@(posedge ck_link) disable iff (!rst_b)
    go && op == 3'b100 && link_dll_off && al_r == 2'b00
    |-> ##1 !wr_data_start [*6] ##1 wr_data_start)
    else $error("write data start misplaced with DLL off");
  chk_odt_dll_off: assert property (@(posedge ck_link) disable iff (!rst_b)
    link_dll_off && $past(link_dll_off) |-> !odt_on)
    else $error("termination on with DLL off");
  chk_odt_follow: assert property (@(posedge ck_link) disable iff (!rst_b)
    odt_on |-> $past(link_odt))
    else $error("termination on without request");
  chk_sref_quiet: assert property (@(posedge ck_link) disable iff (!rst_b)
    sref_r && $past(sref_r) |-> !odt_on && !rd_strobe_start && !wr_data_start)
    else $error("activity during self refresh");
  // The flag is registered after the mode register, so it shows two edges later.
  chk_dll_bit: assert property (@(posedge ck_link) disable iff (!rst_b)
    go && op == 3'b000 && link_cmd.ba == DDMC_MR1_SEL
    |-> ##2 link_dll_off == $past(link_cmd.addr[DDMC_MR1_DLL_DIS_BIT], 2))
    else $error("DLL off flag differs from written bit");
endmodule : ddmc_mode_ctrl_chk

bind ddmc_mode_ctrl ddmc_mode_ctrl_chk i_chk (.clk_sys(clk_sys), .rst_b(rst_b),
  .ck_link(ck_link), .link_cmd(link_cmd), .link_odt(link_odt), .odt_on(odt_on),
  .rd_strobe_start(rd_strobe_start), .wr_data_start(wr_data_start),
  .link_dll_off(link_dll_off));
`default_nettype wire

/* bench/ddmc_mode_ctrl_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module ddmc_mode_ctrl_tb_top;
  import ddmc_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic ck_link, link_odt, rd_strobe_start, wr_data_start, odt_on, link_dll_off;
  ddmc_cmd_s link_cmd;
  logic [31:0] lfsr = 32'h0000_2b14;
  logic [31:0] rq[$];
  logic [31:0] mq[$];
  int pq[$];
  int wq[$];
  logic rd_q = 1'b0;
  logic loose = 1'b0;
  int bad_count = 0;
  int n_compared = 0;
  int k;

  always #4 clk_sys = ~clk_sys;

  ddmc_mode_ctrl i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ck_link(ck_link), .link_cmd(link_cmd), .link_odt(link_odt), .odt_on(odt_on),
    .rd_strobe_start(rd_strobe_start), .wr_data_start(wr_data_start),
    .link_dll_off(link_dll_off));
  ddmc_ctl_model i_ctl (.ck_link(ck_link), .link_cmd(link_cmd), .link_odt(link_odt));

  function automatic logic [31:0] rnd(input logic [31:0] s);
    rnd = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : rnd

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    n_compared++;
    if ((got & m) !== (exp & m))
    begin
      bad_count++;
      $display("ERROR %0t data %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic cmp_edge(input int got, input int exp);
    n_compared++;
    if (got != exp)
    begin
      bad_count++;
      $display("ERROR %0t pulse at edge %0d expected %0d", $time, got, exp);
    end
  endtask : cmp_edge

  task automatic reg_wr_t(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : reg_wr_t

  // The leading wait lets link events cross into the register domain.
  task automatic reg_rd_t(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    repeat (6) @(posedge clk_sys);
    rq.push_back(e);
    mq.push_back(m);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask : reg_rd_t

  task automatic xfer(input logic [2:0] op, input int lat);
    lfsr = rnd(lfsr);
    i_ctl.issue(1'b1, op, lfsr[2:0], {4'h0, lfsr[9:0]}, k);
    if (!loose && op[0])
      pq.push_back(k + lat + 2);
    else if (!loose)
      wq.push_back(k + lat + 2);
    i_ctl.wait_ck(16);
  endtask : xfer

  task automatic test_done();
    bad_count += pq.size() + wq.size() + rq.size();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  always @(posedge clk_sys)
  begin
    if (rd_q)
      cmp(reg_rdata, rq.pop_front(), mq.pop_front());
    rd_q <= reg_rd;
  end

  always @(posedge ck_link)
  begin
    if (rd_strobe_start && !loose)
      cmp_edge(i_ctl.cyc, pq.size() > 0 ? pq.pop_front() : -1);
    if (wr_data_start && !loose)
      cmp_edge(i_ctl.cyc, wq.size() > 0 ? wq.pop_front() : -1);
  end

  initial
  begin
    #400_000;
    bad_count++;
    test_done();
  end

  initial
  begin
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    i_ctl.wait_ck(4);
    // Lock is reported from the first link edge after reset ends, as no DLL reset is pending yet.
    reg_rd_t(DDMC_REG_STATUS, 32'h0000_000C, 32'h0000_000F);
    reg_rd_t(4'hC, 32'h0000_0000, 32'hFFFF_FFFF);
    xfer(3'b101, 4);
    xfer(3'b100, 5);
    i_ctl.mrs(DDMC_MR1_SEL, 14'h0001, DDMC_MOD_CK);
    i_ctl.sref_in();
    reg_rd_t(DDMC_REG_STATUS, 32'h0000_000B, 32'h0000_000F);
    #600;
    i_ctl.sref_out();
    i_ctl.mrs(DDMC_MR0_SEL, 14'h0020, DDMC_MOD_CK);
    i_ctl.mrs(DDMC_MR2_SEL, 14'h0008, DDMC_MOD_CK);
    xfer(3'b101, 5);
    xfer(3'b100, 6);
    for (int i = 1; i < 3; i++)
    begin
      i_ctl.mrs(DDMC_MR1_SEL, {9'h000, i[1:0], 3'b001}, DDMC_MOD_CK);
      xfer(3'b101, 11 - i);
      xfer(3'b100, 12 - i);
    end
    i_ctl.mrs(DDMC_MR1_SEL, 14'h0001, DDMC_MOD_CK);
    // The read lands inside the update window, so busy joins the latency error.
    i_ctl.mrs(DDMC_MR0_SEL, 14'h0000, 2);
    loose = 1'b1;
    xfer(3'b101, 0);
    reg_rd_t(DDMC_REG_ERR, 32'h0000_0006, 32'h0000_0006);
    reg_wr_t(DDMC_REG_ERR, 32'h0000_0006);
    reg_rd_t(DDMC_REG_ERR, 32'h0000_0000, 32'h0000_0006);
    i_ctl.mrs(DDMC_MR0_SEL, 14'h0020, DDMC_MOD_CK);
    reg_wr_t(DDMC_REG_CTRL, 32'h0000_0001);
    reg_rd_t(DDMC_REG_CTRL, 32'h0000_0001, 32'h0000_0001);
    i_ctl.sref_in();
    i_ctl.sref_out();
    xfer(3'b100, 0);
    reg_rd_t(DDMC_REG_ERR, 32'h0000_0001, 32'h0000_0001);
    reg_wr_t(DDMC_REG_ERR, 32'h0000_0001);
    loose = 1'b0;
    i_ctl.wait_ck(DDMC_VREF_WR_CK);
    xfer(3'b100, 6);
    reg_rd_t(DDMC_REG_ERR, 32'h0000_0000, 32'h0000_0001);
    reg_wr_t(DDMC_REG_CTRL, 32'h0000_0000);
    i_ctl.sref_in();
    i_ctl.sref_out();
    i_ctl.mrs(DDMC_MR1_SEL, 14'h0004, DDMC_MOD_CK);
    i_ctl.mrs(DDMC_MR0_SEL, 14'h0120, DDMC_MOD_CK);
    reg_rd_t(DDMC_REG_STATUS, 32'h0000_0008, 32'h0000_000F);
    i_ctl.wait_ck(DDMC_DLLK_CK);
    reg_rd_t(DDMC_REG_STATUS, 32'h0000_000C, 32'h0000_000F);
    xfer(3'b101, 6);
    xfer(3'b100, 6);
    i_ctl.link_odt <= 1'b1;
    i_ctl.wait_ck(3);
    cmp({31'h0000_0000, odt_on}, 32'h0000_0001, 32'h0000_0001);
    test_done();
  end
endmodule : ddmc_mode_ctrl_tb_top
`default_nettype wire

/* hw/ddmc_mode_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
module ddmc_mode_ctrl
  import ddmc_pkg::*;
(
  // System clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Link side, clocked by the controller-supplied clock
  input wire logic ck_link,
  input wire ddmc_cmd_s link_cmd,
  input wire logic link_odt,
  output logic rd_strobe_start,
  output logic wr_data_start,
  output logic odt_on,
  output logic link_dll_off
);

  // Link-domain reset, released on the link clock.
  // Its release is timed by the link clock, so no link flop sees it near an edge.
  logic [1:0] lrst_sync_r;
  logic lrst_b;

  always_ff @(posedge ck_link or negedge rst_b)
  begin
    if (!rst_b)
      lrst_sync_r <= 2'b00;
    else
      lrst_sync_r <= {lrst_sync_r[0], 1'b1};
  end

  assign lrst_b = lrst_sync_r[1];

  // Command decode; the command pins are synchronous to the link clock.
  logic cke_prev_r;
  logic cmd_sel;
  logic cmd_mrs;
  logic cmd_ref;
  logic cmd_rd;
  logic cmd_wr;
  ddmc_state_e state_r;

  assign cmd_sel = !link_cmd.cs_n && cke_prev_r && state_r == DDMC_ST_ACTIVE;
  assign cmd_mrs = cmd_sel && !link_cmd.ras_n && !link_cmd.cas_n && !link_cmd.we_n;
  assign cmd_ref = cmd_sel && !link_cmd.ras_n && !link_cmd.cas_n && link_cmd.we_n;
  assign cmd_rd = cmd_sel && link_cmd.ras_n && !link_cmd.cas_n && link_cmd.we_n;
  assign cmd_wr = cmd_sel && link_cmd.ras_n && !link_cmd.cas_n && !link_cmd.we_n;

  always_ff @(posedge ck_link or negedge lrst_b)
  begin
    if (!lrst_b)
      cke_prev_r <= 1'b0;
    else
      cke_prev_r <= link_cmd.cke;
  end

  // Self refresh holds all state without any clock edge, so the clock may stop.
  logic sref_exit;

  assign sref_exit = state_r == DDMC_ST_SREF && link_cmd.cke;

  always_ff @(posedge ck_link or negedge lrst_b)
  begin
    if (!lrst_b)
      state_r <= DDMC_ST_ACTIVE;
    else
    begin
      case (state_r)
        DDMC_ST_ACTIVE:
          if (cmd_ref && !link_cmd.cke)
            state_r <= DDMC_ST_SREF;
        DDMC_ST_SREF:
          if (link_cmd.cke)
            state_r <= DDMC_ST_ACTIVE;
        default:
          state_r <= DDMC_ST_ACTIVE;
      endcase
    end
  end

  // Mode registers.
  logic [13:0] mr0_r;
  logic [13:0] mr1_r;
  logic [13:0] mr2_r;
  logic dll_off;

  always_ff @(posedge ck_link or negedge lrst_b)
  begin
    if (!lrst_b)
    begin
      mr0_r <= DDMC_MR_RESET;
      mr1_r <= DDMC_MR_RESET;
      mr2_r <= DDMC_MR_RESET;
    end
    else if (cmd_mrs)
    begin
      case (link_cmd.ba)
        DDMC_MR0_SEL: mr0_r <= link_cmd.addr;
        DDMC_MR1_SEL: mr1_r <= link_cmd.addr;
        DDMC_MR2_SEL: mr2_r <= link_cmd.addr;
        default: mr0_r <= mr0_r;
      endcase
    end
  end

  assign dll_off = mr1_r[DDMC_MR1_DLL_DIS_BIT];

  // The update window is the larger of the set cycle and the update delay.
  logic [9:0] upd_cnt_r;
  logic [9:0] upd_len;

  assign upd_len = (DDMC_MOD_CK > DDMC_MRD_CK) ? DDMC_MOD_CK : DDMC_MRD_CK;

  always_ff @(posedge ck_link or negedge lrst_b)
  begin
    if (!lrst_b)
      upd_cnt_r <= 10'h000;
    else if (cmd_mrs)
      upd_cnt_r <= upd_len - 10'h001;
    else if (upd_cnt_r != 10'h000)
      upd_cnt_r <= upd_cnt_r - 10'h001;
  end

  // DLL lock timer, started by a DLL reset written with the DLL on.
  // A DLL reset written with the DLL off restarts the count, but lock waits for DLL on.
  logic [9:0] lock_cnt_r;
  logic locked_r;

  always_ff @(posedge ck_link or negedge lrst_b)
  begin
    if (!lrst_b)
    begin
      lock_cnt_r <= 10'h000;
      locked_r <= 1'b0;
    end
    else if (cmd_mrs && link_cmd.ba == DDMC_MR0_SEL && link_cmd.addr[DDMC_MR0_DLL_RST_BIT])
    begin
      lock_cnt_r <= DDMC_DLLK_CK - 10'h001;
      locked_r <= 1'b0;
    end
    else if (dll_off)
      locked_r <= 1'b0;
    else if (lock_cnt_r != 10'h000)
      lock_cnt_r <= lock_cnt_r - 10'h001;
    else
      locked_r <= 1'b1;
  end

  // Software tells the link side whether the data reference floats in self refresh.
  logic [1:0] vref_sync_r;
  logic vref_float_r;

  always_ff @(posedge ck_link or negedge lrst_b)
  begin
    if (!lrst_b)
      vref_sync_r <= 2'b00;
    else
      vref_sync_r <= {vref_sync_r[0], vref_float_r};
  end

  // Writes are checked against the reference settling window after exit.
  // The count runs from the exit edge, by which the reference must be valid again.
  logic [9:0] vref_cnt_r;

  always_ff @(posedge ck_link or negedge lrst_b)
  begin
    if (!lrst_b)
      vref_cnt_r <= 10'h000;
    else if (sref_exit && vref_sync_r[1])
      vref_cnt_r <= DDMC_VREF_WR_CK;
    else if (vref_cnt_r != 10'h000)
      vref_cnt_r <= vref_cnt_r - 10'h001;
  end

  // Latencies; with the DLL off the device runs CL 6 and CWL 6 only.
  logic [4:0] cl_eff;
  logic [4:0] cwl_eff;
  logic [4:0] rd_lat;
  logic [4:0] wr_lat;
  logic lat_bad;

  assign cl_eff = dll_off ? DDMC_DLL_OFF_CL : ddmc_cl(mr0_r);
  assign cwl_eff = dll_off ? DDMC_DLL_OFF_CWL : ddmc_cwl(mr2_r);
  // A wrong programmed latency is flagged, not fixed: the device runs 6 regardless.
  assign lat_bad = dll_off && (ddmc_cl(mr0_r) != DDMC_DLL_OFF_CL ||
                               ddmc_cwl(mr2_r) != DDMC_DLL_OFF_CWL);
  // The strobe window opens one cycle earlier with the DLL off.
  assign rd_lat = ddmc_al(mr1_r, cl_eff) + cl_eff - {4'h0, dll_off};
  // Write timing takes no DLL-off shift; the DLL state enters only through cl_eff and cwl_eff.
  assign wr_lat = ddmc_al(mr1_r, cl_eff) + cwl_eff;

  // Command delay lines; bit k marks a command issued k + 1 cycles ago.
  // A 32-bit line covers the longest latency that the mode fields can reach.
  logic [31:0] rd_pipe_r;
  logic [31:0] wr_pipe_r;

  always_ff @(posedge ck_link or negedge lrst_b)
  begin
    if (!lrst_b)
    begin
      rd_pipe_r <= 32'h0000_0000;
      wr_pipe_r <= 32'h0000_0000;
    end
    else
    begin
      rd_pipe_r <= {rd_pipe_r[30:0], cmd_rd};
      wr_pipe_r <= {wr_pipe_r[30:0], cmd_wr};
    end
  end

  // The output register adds one edge, so the tap sits one below the latency and the
  // pulse stands in the cycle that begins at the marked edge.
  function automatic logic [4:0] pipe_tap(input logic [4:0] lat);
    pipe_tap = lat - DDMC_OUT_REG_CK;
  endfunction : pipe_tap

  // Only the window start is marked here; the strobe delay past it is the
  // controller's to absorb, since data still follows the strobe.
  always_ff @(posedge ck_link or negedge lrst_b)
  begin
    if (!lrst_b)
    begin
      rd_strobe_start <= 1'b0;
      wr_data_start <= 1'b0;
    end
    else
    begin
      rd_strobe_start <= rd_pipe_r[pipe_tap(rd_lat)];
      wr_data_start <= wr_pipe_r[pipe_tap(wr_lat)];
    end
  end

  // Termination is forced off with the DLL off or in self refresh.
  // Gating on the mode fields too keeps a stray pin level from switching termination.
  logic rtt_en;

  assign rtt_en = mr1_r[DDMC_MR1_RTT_B0] || mr1_r[DDMC_MR1_RTT_B1] ||
                  mr1_r[DDMC_MR1_RTT_B2] ||
                  mr2_r[DDMC_MR2_RTTWR_HI:DDMC_MR2_RTTWR_LO] != 2'b00;

  always_ff @(posedge ck_link or negedge lrst_b)
  begin
    if (!lrst_b)
    begin
      odt_on <= 1'b0;
      link_dll_off <= 1'b0;
    end
    else
    begin
      odt_on <= link_odt && rtt_en && !dll_off && state_r == DDMC_ST_ACTIVE;
      link_dll_off <= dll_off;
    end
  end

  // Error events toggle so a single slow-domain edge cannot be missed.
  logic [2:0] err_tgl_r;
  logic [2:0] err_evt;

  assign err_evt[DDMC_ERR_WRITE_EARLY] = cmd_wr && vref_cnt_r != 10'h000;
  assign err_evt[DDMC_ERR_LATENCY] = (cmd_rd || cmd_wr) && lat_bad;
  assign err_evt[DDMC_ERR_BUSY] = cmd_sel && !(link_cmd.ras_n && link_cmd.cas_n &&
                                  link_cmd.we_n) && upd_cnt_r != 10'h000;

  always_ff @(posedge ck_link or negedge lrst_b)
  begin
    if (!lrst_b)
      err_tgl_r <= 3'b000;
    else
      err_tgl_r <= err_tgl_r ^ err_evt;
  end

  // System domain: level and toggle synchronisers.
  // The status bits are independent levels, so a one-cycle skew between them is harmless.
  logic [6:0] sys_s1_r;
  logic [6:0] sys_s2_r;
  logic [2:0] tgl_s3_r;
  logic [2:0] err_r;
  logic [2:0] err_hit;
  logic [6:0] cross_in;

  assign cross_in = {err_tgl_r, upd_cnt_r == 10'h000, locked_r,
                     state_r == DDMC_ST_SREF, dll_off};
  assign err_hit = sys_s2_r[6:4] ^ tgl_s3_r;

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sys_s1_r <= 7'h00;
      sys_s2_r <= 7'h00;
      tgl_s3_r <= 3'b000;
    end
    else
    begin
      sys_s1_r <= cross_in;
      sys_s2_r <= sys_s1_r;
      tgl_s3_r <= sys_s2_r[6:4];
    end
  end

  // Sticky errors, cleared by writing ones; a new event wins over the clear.
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      err_r <= 3'b000;
    else if (reg_wr && reg_addr == DDMC_REG_ERR)
      err_r <= (err_r & ~reg_wdata[2:0]) | err_hit;
    else
      err_r <= err_r | err_hit;
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      vref_float_r <= 1'b0;
    else if (reg_wr && reg_addr == DDMC_REG_CTRL)
      vref_float_r <= reg_wdata[DDMC_CTRL_VREF_FLOAT];
  end

  // Read data stand for one cycle only; unmapped reads return zero.
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
    begin
      case (reg_addr)
        DDMC_REG_STATUS: reg_rdata <= {28'h000_0000, sys_s2_r[3:0]};
        DDMC_REG_CTRL: reg_rdata <= {31'h0000_0000, vref_float_r};
        DDMC_REG_ERR: reg_rdata <= {29'h0000_0000, err_r};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end
    else
      reg_rdata <= 32'h0000_0000;
  end

endmodule : ddmc_mode_ctrl
`default_nettype wire

/* hw/ddmc_pkg.sv */
// Operation
// - In self refresh the device keeps its contents and needs no toggling clock.
// - With the DLL off, only read latency 6 and write latency 6 are supported.
// - The read strobe window starts at AL + CL with the DLL on and AL + CL - 1 with it off.
// - With the DLL off the strobe may lag the clock by over a period; data stays with strobe.
// - After mode writes the next command waits the larger of set cycle and update delay.
// - Writes behave alike with the DLL on or off, except that termination is unavailable.
package ddmc_pkg;

  typedef struct packed {
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [2:0] ba;
    logic [13:0] addr;
  } ddmc_cmd_s;

  typedef enum logic [0:0] {
    DDMC_ST_ACTIVE,
    DDMC_ST_SREF
  } ddmc_state_e;

  // Link timing counts, in link clock cycles.
  localparam logic [9:0] DDMC_MRD_CK = 10'h004;
  localparam logic [9:0] DDMC_MOD_CK = 10'h00C;
  localparam logic [9:0] DDMC_DLLK_CK = 10'h200;
  localparam logic [9:0] DDMC_VREF_WR_CK = 10'h200;
  localparam logic [4:0] DDMC_DLL_OFF_CL = 5'h06;
  localparam logic [4:0] DDMC_DLL_OFF_CWL = 5'h06;
  localparam logic [4:0] DDMC_CL_BASE = 5'h04;
  localparam logic [4:0] DDMC_CWL_BASE = 5'h05;
  localparam logic [4:0] DDMC_OUT_REG_CK = 5'h01;

  // Mode register select codes and field positions.
  localparam logic [2:0] DDMC_MR0_SEL = 3'h0;
  localparam logic [2:0] DDMC_MR1_SEL = 3'h1;
  localparam logic [2:0] DDMC_MR2_SEL = 3'h2;
  localparam int DDMC_MR1_DLL_DIS_BIT = 0;
  localparam int DDMC_MR0_DLL_RST_BIT = 8;
  localparam int DDMC_MR1_RTT_B0 = 2;
  localparam int DDMC_MR1_RTT_B1 = 6;
  localparam int DDMC_MR1_RTT_B2 = 9;
  localparam int DDMC_MR2_RTTWR_HI = 10;
  localparam int DDMC_MR2_RTTWR_LO = 9;
  localparam int DDMC_MR0_CL_HI = 6;
  localparam int DDMC_MR0_CL_LO = 4;
  localparam int DDMC_MR1_AL_HI = 4;
  localparam int DDMC_MR1_AL_LO = 3;
  localparam int DDMC_MR2_CWL_HI = 5;
  localparam int DDMC_MR2_CWL_LO = 3;
  localparam logic [13:0] DDMC_MR_RESET = 14'h0000;

  // Register bus map.
  localparam logic [3:0] DDMC_REG_STATUS = 4'h0;
  localparam logic [3:0] DDMC_REG_CTRL = 4'h4;
  localparam logic [3:0] DDMC_REG_ERR = 4'h8;
  localparam int DDMC_STAT_DLL_OFF = 0;
  localparam int DDMC_STAT_SREF = 1;
  localparam int DDMC_STAT_LOCKED = 2;
  localparam int DDMC_STAT_READY = 3;
  localparam int DDMC_ERR_WRITE_EARLY = 0;
  localparam int DDMC_ERR_LATENCY = 1;
  localparam int DDMC_ERR_BUSY = 2;
  localparam int DDMC_CTRL_VREF_FLOAT = 0;

  function automatic logic [4:0] ddmc_cl(input logic [13:0] mr0);
    ddmc_cl = DDMC_CL_BASE + {2'b00, mr0[DDMC_MR0_CL_HI:DDMC_MR0_CL_LO]};
  endfunction : ddmc_cl

  function automatic logic [4:0] ddmc_cwl(input logic [13:0] mr2);
    ddmc_cwl = DDMC_CWL_BASE + {2'b00, mr2[DDMC_MR2_CWL_HI:DDMC_MR2_CWL_LO]};
  endfunction : ddmc_cwl

  function automatic logic [4:0] ddmc_al(input logic [13:0] mr1, input logic [4:0] cl);
    case (mr1[DDMC_MR1_AL_HI:DDMC_MR1_AL_LO])
      2'b01: ddmc_al = cl - 5'h01;
      2'b10: ddmc_al = cl - 5'h02;
      default: ddmc_al = 5'h00;
    endcase
  endfunction : ddmc_al

endpackage : ddmc_pkg
